// >>> rtl/urlsf_pkg.sv
// Shared constants and types for the receiver line status flag block
package urlsf_pkg;

	// Register port addresses
	localparam int         URLSF_ADDR_W      = 3;
	localparam logic [2:0] URLSF_ADDR_DATA   = 3'h0;
	localparam logic [2:0] URLSF_ADDR_CONFIG = 3'h3;
	localparam logic [2:0] URLSF_ADDR_STATUS = 3'h5;
	localparam logic [2:0] URLSF_ADDR_LEVEL  = 3'h6;

	// Receive storage sizing
	localparam int         URLSF_FIFO_DEPTH   = 16;
	localparam int         URLSF_PTR_W        = 4;
	localparam int         URLSF_CNT_W        = 5;
	localparam logic [4:0] URLSF_FIFO_FULL    = 5'h10;
	localparam logic [4:0] URLSF_HOLD_FULL    = 5'h01;
	localparam logic [4:0] URLSF_CNT_RESET    = 5'h00;
	localparam logic [3:0] URLSF_PTR_RESET    = 4'h0;
	localparam logic [3:0] URLSF_PTR_ONE      = 4'h1;
	localparam logic [4:0] URLSF_CNT_ONE      = 5'h01;

	// Word length codes
	localparam logic [1:0] URLSF_WLEN_5 = 2'h0;
	localparam logic [1:0] URLSF_WLEN_6 = 2'h1;
	localparam logic [1:0] URLSF_WLEN_7 = 2'h2;
	localparam logic [1:0] URLSF_WLEN_8 = 2'h3;

	typedef struct packed {
		logic [2:0] rsvd;
		logic       fifo_en;
		logic       par_even;
		logic       par_en;
		logic [1:0] wlen;
	} urlsf_cfg_t;

	typedef struct packed {
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} urlsf_entry_t;

	typedef struct packed {
		logic [3:0] rsvd;
		logic       fe;
		logic       pe;
		logic       ovr;
		logic       ready;
	} urlsf_status_t;

	// Reset values
	localparam urlsf_cfg_t   URLSF_CFG_RESET   = 8'h03;
	localparam urlsf_entry_t URLSF_ENTRY_RESET = 10'h000;
	localparam logic [7:0]   URLSF_BYTE_ZERO   = 8'h00;

endpackage

// >>> rtl/urlsf_fifo.sv
// Flip-flop receive FIFO carrying each character with its error flags
`timescale 1ns/1ns
module urlsf_fifo
(
	// Clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              rst_b_in,
	// Control
	input  wire logic                              flush_in,
	input  wire logic                              push_in,
	input  wire logic                              pop_in,
	input  wire urlsf_pkg::urlsf_entry_t           push_entry_in,
	// State
	output      urlsf_pkg::urlsf_entry_t           top_entry_out,
	output      logic [urlsf_pkg::URLSF_CNT_W-1:0] count_out,
	output      logic [urlsf_pkg::URLSF_CNT_W-1:0] count_next_out
);

	urlsf_pkg::urlsf_entry_t             mem_reg [urlsf_pkg::URLSF_FIFO_DEPTH];
	logic [urlsf_pkg::URLSF_PTR_W-1:0]   wr_ptr_reg;
	logic [urlsf_pkg::URLSF_PTR_W-1:0]   rd_ptr_reg;
	logic [urlsf_pkg::URLSF_CNT_W-1:0]   count_reg;
	logic                                push_ok;
	logic                                pop_ok;

	// Guards here too, so a stray strobe cannot wrap a pointer
	assign push_ok = push_in && !flush_in && (count_reg != urlsf_pkg::URLSF_FIFO_FULL);
	assign pop_ok  = pop_in && !flush_in && (count_reg != urlsf_pkg::URLSF_CNT_RESET);

	genvar i;
	generate
		for (i = 0; i < urlsf_pkg::URLSF_FIFO_DEPTH; i++)
		begin : g_entry
			localparam logic [urlsf_pkg::URLSF_PTR_W-1:0] ENTRY_IDX = urlsf_pkg::URLSF_PTR_W'(i);
			always_ff @(posedge clk_in)
			begin
				if (!rst_b_in)
					mem_reg[i] <= urlsf_pkg::URLSF_ENTRY_RESET;
				else if (push_ok && (wr_ptr_reg == ENTRY_IDX))
					mem_reg[i] <= push_entry_in;
			end
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || flush_in)
			wr_ptr_reg <= urlsf_pkg::URLSF_PTR_RESET;
		else if (push_ok)
			wr_ptr_reg <= wr_ptr_reg + urlsf_pkg::URLSF_PTR_ONE;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in || flush_in)
			rd_ptr_reg <= urlsf_pkg::URLSF_PTR_RESET;
		else if (pop_ok)
			rd_ptr_reg <= rd_ptr_reg + urlsf_pkg::URLSF_PTR_ONE;
	end

	always_comb
	begin
		count_next_out = count_reg;
		if (flush_in)
			count_next_out = urlsf_pkg::URLSF_CNT_RESET;
		else if (push_ok && !pop_ok)
			count_next_out = count_reg + urlsf_pkg::URLSF_CNT_ONE;
		else if (pop_ok && !push_ok)
			count_next_out = count_reg - urlsf_pkg::URLSF_CNT_ONE;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			count_reg <= urlsf_pkg::URLSF_CNT_RESET;
		else
			count_reg <= count_next_out;
	end

	assign count_out     = count_reg;
	assign top_entry_out = mem_reg[rd_ptr_reg];

endmodule

// >>> rtl/urlsf_top.sv
// Receiver line status flags: shift register, receive FIFO and status register
//
// Behaviour
// - A character without a valid stop bit raises the framing flag, and in FIFO mode the flag follows the top character.
// - A character whose parity differs from the set parity raises status bit 2, following the top character in FIFO mode.
// - Status bit 1 is raised when a character completes while the receive storage is already full.
// - On overrun the shift register is overwritten by the new character.
// - On overrun nothing is pushed, so characters already stored stay intact.
// - Status bit 0 is high whenever at least one character is held in the holding register or FIFO.
// - The data ready bit is low whenever no character is held.
`timescale 1ns/1ns
module urlsf_top
(
	// Clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              rst_b_in,
	// Completed character from the serial front end
	input  wire logic                              rx_done_in,
	input  wire logic [7:0]                        rx_data_in,
	input  wire logic                              rx_parity_bit_in,
	input  wire logic                              rx_stop_bit_in,
	// Register port
	input  wire logic [urlsf_pkg::URLSF_ADDR_W-1:0] addr_in,
	input  wire logic [7:0]                        wr_data_in,
	input  wire logic                              wr_en_in,
	input  wire logic                              rd_en_in,
	output      logic [7:0]                        rd_data_out,
	// Status
	output      logic                              rx_ready_out
);

	urlsf_pkg::urlsf_cfg_t               cfg_reg;
	urlsf_pkg::urlsf_cfg_t               cfg_next;
	urlsf_pkg::urlsf_entry_t             rsr_reg;
	urlsf_pkg::urlsf_entry_t             new_entry;
	urlsf_pkg::urlsf_entry_t             top_entry;
	urlsf_pkg::urlsf_status_t            status;
	logic                                ovr_reg;
	logic [7:0]                          rd_data_reg;
	logic [7:0]                          rd_data_next;
	logic                                ready_reg;
	logic [urlsf_pkg::URLSF_CNT_W-1:0]   count;
	logic [urlsf_pkg::URLSF_CNT_W-1:0]   count_next;
	logic [urlsf_pkg::URLSF_CNT_W-1:0]   full_level;
	logic                                full;
	logic                                overrun_evt;
	logic                                push;
	logic                                pop;
	logic                                flush;
	logic                                cfg_wr;
	logic                                status_rd;
	logic                                data_rd;
	logic                                level_rd;
	logic [7:0]                          len_mask;
	logic [7:0]                          data_masked;
	logic                                par_sum;

	// Register port decode
	assign cfg_wr    = wr_en_in && (addr_in == urlsf_pkg::URLSF_ADDR_CONFIG);
	assign status_rd = rd_en_in && (addr_in == urlsf_pkg::URLSF_ADDR_STATUS);
	assign data_rd   = rd_en_in && (addr_in == urlsf_pkg::URLSF_ADDR_DATA);
	assign level_rd  = rd_en_in && (addr_in == urlsf_pkg::URLSF_ADDR_LEVEL);

	always_comb
	begin
		cfg_next      = wr_data_in;
		cfg_next.rsvd = 3'h0;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			cfg_reg <= urlsf_pkg::URLSF_CFG_RESET;
		else if (cfg_wr)
			cfg_reg <= cfg_next;
	end

	// Switching mode empties storage; stale entries would mix two depths
	assign flush = cfg_wr && (cfg_next.fifo_en != cfg_reg.fifo_en);

	// Character checking
	always_comb
	begin
		case (cfg_reg.wlen)
			urlsf_pkg::URLSF_WLEN_5: len_mask = 8'h1f;
			urlsf_pkg::URLSF_WLEN_6: len_mask = 8'h3f;
			urlsf_pkg::URLSF_WLEN_7: len_mask = 8'h7f;
			default:                 len_mask = 8'hff;
		endcase
	end

	assign data_masked = rx_data_in & len_mask;
	assign par_sum     = (^data_masked) ^ rx_parity_bit_in;

	always_comb
	begin
		new_entry.data = data_masked;
		// Even parity fails on an odd sum, odd parity on an even sum
		new_entry.pe   = cfg_reg.par_en && (par_sum == cfg_reg.par_even);
		new_entry.fe   = !rx_stop_bit_in;
	end

	// Holding register mode is the same storage limited to one entry
	assign full_level  = cfg_reg.fifo_en ? urlsf_pkg::URLSF_FIFO_FULL : urlsf_pkg::URLSF_HOLD_FULL;
	assign full        = (count >= full_level);
	assign overrun_evt = rx_done_in && full;
	assign push        = rx_done_in && !full;
	assign pop         = data_rd && (count != urlsf_pkg::URLSF_CNT_RESET);

	// Shift register always takes the newest character
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			rsr_reg <= urlsf_pkg::URLSF_ENTRY_RESET;
		else if (rx_done_in)
			rsr_reg <= new_entry;
	end

	urlsf_fifo u_fifo
	(
		.clk_in         (clk_in),
		.rst_b_in       (rst_b_in),
		.flush_in       (flush),
		.push_in        (push),
		.pop_in         (pop),
		.push_entry_in  (new_entry),
		.top_entry_out  (top_entry),
		.count_out      (count),
		.count_next_out (count_next)
	);

	// Overrun is sticky until a status read; a new overrun beats the clear
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			ovr_reg <= 1'b0;
		else if (overrun_evt)
			ovr_reg <= 1'b1;
		else if (status_rd)
			ovr_reg <= 1'b0;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			ready_reg <= 1'b0;
		else
			ready_reg <= (count_next != urlsf_pkg::URLSF_CNT_RESET);
	end

	// Error flags track the top entry only while it exists
	always_comb
	begin
		status       = 8'h00;
		status.ready = (count != urlsf_pkg::URLSF_CNT_RESET);
		status.ovr   = ovr_reg;
		status.pe    = status.ready && top_entry.pe;
		status.fe    = status.ready && top_entry.fe;
	end

	always_comb
	begin
		rd_data_next = urlsf_pkg::URLSF_BYTE_ZERO;
		if (status_rd)
			rd_data_next = status;
		else if (data_rd)
			rd_data_next = pop ? top_entry.data : urlsf_pkg::URLSF_BYTE_ZERO;
		else if (rd_en_in && (addr_in == urlsf_pkg::URLSF_ADDR_CONFIG))
			rd_data_next = cfg_reg;
		else if (level_rd)
			rd_data_next = {3'h0, count};
	end

	// Read data stands for exactly one cycle after the strobe
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			rd_data_reg <= urlsf_pkg::URLSF_BYTE_ZERO;
		else
			rd_data_reg <= rd_data_next;
	end

	assign rd_data_out  = rd_data_reg;
	assign rx_ready_out = ready_reg;

	// Checks

	AST_FE_TOP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		status_rd && (count != urlsf_pkg::URLSF_CNT_RESET) |=> rd_data_out[3] == $past(top_entry.fe))
		else $error("framing flag does not follow top entry");

	AST_FE_STORE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rx_done_in && !full && !flush && (count == urlsf_pkg::URLSF_CNT_RESET)
		|=> (top_entry.fe == !$past(rx_stop_bit_in)) && (top_entry.pe == $past(new_entry.pe)))
		else $error("stored flags differ from received character");

	AST_PE_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		push && !flush && (count == urlsf_pkg::URLSF_CNT_RESET) && !cfg_reg.par_en |=> !status.pe)
		else $error("parity flag set while parity checking is off");

	AST_PE_TOP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		status_rd |=> rd_data_out[2] == $past(status.ready && top_entry.pe))
		else $error("parity flag does not follow top entry");

	AST_OVR_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rx_done_in && (count >= full_level) |=> ovr_reg ##1 (ovr_reg || $past(status_rd)))
		else $error("overrun not flagged on full storage");

	AST_OVR_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		status_rd && !overrun_evt |=> !ovr_reg)
		else $error("overrun not cleared by status read");

	AST_RSR_LOAD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rx_done_in |=> rsr_reg.data == ($past(rx_data_in) & $past(len_mask)))
		else $error("shift register not overwritten");

	AST_NO_PUSH_FULL: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rx_done_in && full && !pop && !flush |=> $stable(count) && $stable(top_entry))
		else $error("storage changed during overrun");

	AST_READY_HIGH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(count != urlsf_pkg::URLSF_CNT_RESET) |-> rx_ready_out && status.ready)
		else $error("data ready low while data held");

	AST_READY_LOW: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(count == urlsf_pkg::URLSF_CNT_RESET) |-> !rx_ready_out && !status.ready)
		else $error("data ready high while empty");

	AST_PUSH_COUNT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		push && !pop && !flush
		|=> count == $past(count) + urlsf_pkg::URLSF_CNT_ONE)
		else $error("accepted character not counted");

	AST_POP_COUNT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pop && !push && !flush
		|=> count == $past(count) - urlsf_pkg::URLSF_CNT_ONE)
		else $error("read character not removed");

	AST_COUNT_BOUND: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		count <= full_level)
		else $error("storage count beyond its depth");

	AST_OVR_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		ovr_reg && !status_rd
		|=> ovr_reg)
		else $error("overrun lost without a status read");

	AST_OVR_ONLY_EVT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!ovr_reg && !overrun_evt
		|=> !ovr_reg)
		else $error("overrun raised without a full storage");

	AST_OVR_RD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		status_rd
		|=> rd_data_out[1] == $past(ovr_reg))
		else $error("overrun bit misreported");

	AST_STATUS_EMPTY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		status_rd && (count == urlsf_pkg::URLSF_CNT_RESET)
		|=> rd_data_out[3:0] == {2'h0, $past(ovr_reg), 1'h0})
		else $error("status flags set while empty");

	AST_READY_RD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		status_rd && (count != urlsf_pkg::URLSF_CNT_RESET)
		|=> rd_data_out[0])
		else $error("data ready bit low in status read");

	AST_DATA_TOP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		data_rd && (count != urlsf_pkg::URLSF_CNT_RESET)
		|=> rd_data_out == $past(top_entry.data))
		else $error("data read differs from top entry");

	AST_DATA_EMPTY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		data_rd && !rx_done_in && (count == urlsf_pkg::URLSF_CNT_RESET)
		|=> (rd_data_out == urlsf_pkg::URLSF_BYTE_ZERO) && (count == urlsf_pkg::URLSF_CNT_RESET))
		else $error("empty data read returned data");

	AST_RD_IDLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!rd_en_in
		|=> rd_data_out == urlsf_pkg::URLSF_BYTE_ZERO)
		else $error("read data standing without a read");

	AST_FULL_NO_GROW: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		full && !flush
		|=> count <= $past(count))
		else $error("full storage grew");

	AST_RSR_FLAGS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rx_done_in
		|=> rsr_reg.fe == !$past(rx_stop_bit_in))
		else $error("shift register flags not overwritten");

	AST_FE_CLEAN: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		push && !flush && (count == urlsf_pkg::URLSF_CNT_RESET) && rx_stop_bit_in
		|=> !status.fe)
		else $error("framing flag set for a good stop bit");

	AST_FE_SET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		push && !flush && (count == urlsf_pkg::URLSF_CNT_RESET) && !rx_stop_bit_in
		|=> status.fe)
		else $error("framing flag missing for a bad stop bit");

	AST_FLUSH_EMPTY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		flush
		|=> (count == urlsf_pkg::URLSF_CNT_RESET) && !rx_ready_out)
		else $error("mode change left storage filled");

	AST_LEVEL_RD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		level_rd
		|=> rd_data_out == {3'h0, $past(count)})
		else $error("level read differs from storage count");

endmodule

// >>> verif/urlsf_tx_model.sv
// Behavioural remote transmitter handing completed characters to the receiver
`timescale 1ns/1ns
module urlsf_tx_model
(
	// Clock
	input  wire logic       clk_in,
	// Completed character
	output      logic       rx_done_out,
	output      logic [7:0] rx_data_out,
	output      logic       rx_parity_bit_out,
	output      logic       rx_stop_bit_out
);
	initial
	begin
		rx_done_out = 1'b0;
		rx_data_out = 8'h00;
		rx_parity_bit_out = 1'b0;
		rx_stop_bit_out = 1'b1;
	end

	task automatic send(input logic [7:0] data, input logic par, input logic stop);
	begin
		@(posedge clk_in);
		rx_done_out <= 1'b1;
		rx_data_out <= data;
		rx_parity_bit_out <= par;
		rx_stop_bit_out <= stop;
		@(posedge clk_in);
		rx_done_out <= 1'b0;
		// Lines are not held past the pulse, so stale values cannot pass
		rx_data_out <= ~data;
		rx_parity_bit_out <= ~par;
		rx_stop_bit_out <= ~stop;
	end
	endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the receiver line status flag block
`timescale 1ns/1ns
module testbench;
	logic       clk_in;
	logic       rst_b_in;
	logic [2:0] addr_in;
	logic [7:0] wr_data_in;
	logic       wr_en_in;
	logic       rd_en_in;
	logic [7:0] rd_data_out;
	logic       rx_ready_out;
	logic       rx_done;
	logic [7:0] rx_data;
	logic       rx_par;
	logic       rx_stop;
	int         n_mismatch;
	int         cmp_count;

	urlsf_top urlsf_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .rx_done_in(rx_done), .rx_data_in(rx_data),
		.rx_parity_bit_in(rx_par), .rx_stop_bit_in(rx_stop), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .rx_ready_out(rx_ready_out));
	urlsf_tx_model urlsf_tx_model_i (.clk_in(clk_in), .rx_done_out(rx_done), .rx_data_out(rx_data),
		.rx_parity_bit_out(rx_par), .rx_stop_bit_out(rx_stop));

	initial clk_in = 1'b0;
	always #4 clk_in = ~clk_in;

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
	begin
		@(posedge clk_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	end
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdc(input string name, input logic [2:0] a, input logic [7:0] exp);
	begin
		@(posedge clk_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk(name, exp, rd_data_out);
	end
	endtask

	task automatic t_reset;
	begin
		chk("ready pin", 8'h00, {7'h00, rx_ready_out});
		rdc("status", urlsf_pkg::URLSF_ADDR_STATUS, 8'h00);
		rdc("config", urlsf_pkg::URLSF_ADDR_CONFIG, 8'h03);
		@(posedge clk_in);
		#1;
		chk("read data idle", 8'h00, rd_data_out);
		wr(urlsf_pkg::URLSF_ADDR_STATUS, 8'hff);
		rdc("status after write", urlsf_pkg::URLSF_ADDR_STATUS, 8'h00);
		rdc("unmapped", 3'h7, 8'h00);
		rdc("empty data", urlsf_pkg::URLSF_ADDR_DATA, 8'h00);
		$display("test reset done");
	end
	endtask

	task automatic t_flags;
	begin
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h1f);
		urlsf_tx_model_i.send(8'h41, 1'b0, 1'b1);
		urlsf_tx_model_i.send(8'h41, 1'b1, 1'b1);
		urlsf_tx_model_i.send(8'h43, 1'b1, 1'b0);
		#1;
		chk("ready pin", 8'h01, {7'h00, rx_ready_out});
		rdc("status good", urlsf_pkg::URLSF_ADDR_STATUS, 8'h01);
		rdc("data 1", urlsf_pkg::URLSF_ADDR_DATA, 8'h41);
		rdc("status parity", urlsf_pkg::URLSF_ADDR_STATUS, 8'h05);
		rdc("data 2", urlsf_pkg::URLSF_ADDR_DATA, 8'h41);
		rdc("status framing", urlsf_pkg::URLSF_ADDR_STATUS, 8'h09);
		rdc("data 3", urlsf_pkg::URLSF_ADDR_DATA, 8'h43);
		rdc("status empty", urlsf_pkg::URLSF_ADDR_STATUS, 8'h00);
		chk("ready pin", 8'h00, {7'h00, rx_ready_out});
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h17);
		urlsf_tx_model_i.send(8'h41, 1'b0, 1'b1);
		rdc("status odd", urlsf_pkg::URLSF_ADDR_STATUS, 8'h05);
		rdc("data odd", urlsf_pkg::URLSF_ADDR_DATA, 8'h41);
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h10);
		urlsf_tx_model_i.send(8'hff, 1'b1, 1'b1);
		rdc("status parity off", urlsf_pkg::URLSF_ADDR_STATUS, 8'h01);
		rdc("data 5 bit", urlsf_pkg::URLSF_ADDR_DATA, 8'h1f);
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h15);
		urlsf_tx_model_i.send(8'h41, 1'b0, 1'b1);
		rdc("status 6 bit", urlsf_pkg::URLSF_ADDR_STATUS, 8'h01);
		rdc("data 6 bit", urlsf_pkg::URLSF_ADDR_DATA, 8'h01);
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h12);
		urlsf_tx_model_i.send(8'hff, 1'b0, 1'b1);
		rdc("data 7 bit", urlsf_pkg::URLSF_ADDR_DATA, 8'h7f);
		$display("test flags done");
	end
	endtask

	task automatic t_overrun;
	begin
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h13);
		for (int i = 0; i < 16; i++)
			urlsf_tx_model_i.send(8'(i), 1'b0, 1'b1);
		urlsf_tx_model_i.send(8'hee, 1'b0, 1'b1);
		rdc("level", urlsf_pkg::URLSF_ADDR_LEVEL, 8'h10);
		rdc("status overrun", urlsf_pkg::URLSF_ADDR_STATUS, 8'h03);
		rdc("status cleared", urlsf_pkg::URLSF_ADDR_STATUS, 8'h01);
		for (int i = 0; i < 16; i++)
			rdc("fifo data", urlsf_pkg::URLSF_ADDR_DATA, 8'(i));
		rdc("status drained", urlsf_pkg::URLSF_ADDR_STATUS, 8'h00);
		$display("test overrun done");
	end
	endtask

	task automatic t_hold;
	begin
		// Leaving FIFO mode flushes storage
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h03);
		urlsf_tx_model_i.send(8'h5a, 1'b0, 1'b1);
		urlsf_tx_model_i.send(8'ha5, 1'b0, 1'b1);
		rdc("hold overrun", urlsf_pkg::URLSF_ADDR_STATUS, 8'h03);
		rdc("hold data", urlsf_pkg::URLSF_ADDR_DATA, 8'h5a);
		rdc("hold empty", urlsf_pkg::URLSF_ADDR_STATUS, 8'h00);
		$display("test hold done");
	end
	endtask

	task automatic t_midreset;
	begin
		wr(urlsf_pkg::URLSF_ADDR_CONFIG, 8'h07);
		urlsf_tx_model_i.send(8'h3c, 1'b0, 1'b0);
		urlsf_tx_model_i.send(8'hc3, 1'b0, 1'b1);
		rdc("level before reset", urlsf_pkg::URLSF_ADDR_LEVEL, 8'h01);
		@(posedge clk_in);
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		#1;
		chk("ready after reset", 8'h00, {7'h00, rx_ready_out});
		chk("read data after reset", 8'h00, rd_data_out);
		rdc("status after reset", urlsf_pkg::URLSF_ADDR_STATUS, 8'h00);
		rdc("config after reset", urlsf_pkg::URLSF_ADDR_CONFIG, 8'h03);
		rdc("level after reset", urlsf_pkg::URLSF_ADDR_LEVEL, 8'h00);
		$display("test midreset done");
	end
	endtask

	task automatic summarize;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		summarize();
	end

	initial
	begin
		n_mismatch = 0;
		cmp_count = 0;
		rst_b_in = 1'b0;
		addr_in = 3'h0;
		wr_data_in = 8'h00;
		wr_en_in = 1'b0;
		rd_en_in = 1'b0;
		repeat (5) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_flags();
		t_overrun();
		t_hold();
		t_midreset();
		summarize();
	end
endmodule
